// ### hdl/lan_attention_irq_handshake.sv
// Purpose: Attention/interrupt handshake, receive unit state control and loss tallies.
// Assumes: Host reaches the control block over Avalon-MM; attention pin is asynchronous.
// Notes:   The memory-resident control block is modelled by registers in this block.
//
// Behaviour
// [RQ1] Clear end, suspend set: suspend, not-ready interrupt.
// [RQ2] End set only: no resources, start readies.
// [RQ3] Both set: idle, start readies unit.
// [RQ4] Each received frame raises frame-received cause.
// [RQ5] Frames during unit start may drop.
// [RQ6] Dropped frames bump resource or overrun tally.
// [RQ7] Interrupt carries four causes.
// [RQ8] Line low, status written, then line high.
// [RQ9] Host waits for cleared command word.
// [RQ10] Host acks, writes commands, falls attention.
// [RQ11] Attention clears acks, accepts, re-raises if pending.
// [RQ12] After reset, line low until attention.
// [RQ13] Init posts done and not-ready, units idle.
// [RQ14] Host acks init causes and starts units.
// [RQ15] Command unit finishes busy work before accepting.
// [RQ16] Receive unit accepts after its busy work.
// [RQ17] Command word cleared after both accept.
// [RQ18] Attention edge latched, cleared before command read.
// [RQ19] Attention handling never waits for frames.
// [RQ20] Bus held through whole descriptor access.
// [RQ21] Host leaves structures alone when grant dropped.
// [RQ22] First attention reads root pointer address.
// [RQ23] Init locates control block page.
// [RQ24] Descriptor end and suspend flags steer unit.
// [RQ25] Status written before interrupt line rises.
`timescale 1ns/1ps
module lan_attention_irq_handshake #(
  parameter int TALLY_W = 16  // Width of each error tally.
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  // Avalon-MM slave.
  input  wire logic [3:0]                i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [31:0]               i_avs_writedata,
  input  wire logic [3:0]                i_avs_byteenable,
  output logic      [31:0]               o_avs_readdata,
  output logic                           o_avs_waitrequest,
  // Link-side events.
  input  wire logic                      i_attention_strobe,    // Asynchronous pin, falling edge acts.
  input  wire logic                      i_frame_received_event, // One-cycle pulse per good frame.
  input  wire logic                      i_frame_lost_event,    // One-cycle pulse per lost frame.
  input  wire logic                      i_crc_error_event,     // One-cycle pulse.
  input  wire logic                      i_align_error_event,   // One-cycle pulse.
  input  wire logic                      i_overrun_state,       // Selects overrun tally on loss.
  input  wire logic                      i_command_done_event,  // Block with done-interrupt flag finished.
  input  wire logic                      i_command_unit_idle_event, // Command unit went not ready.
  input  wire logic                      i_command_unit_busy,   // Prefetch, buffer switch or completion.
  input  wire logic                      i_receive_unit_busy,   // Prefetch, buffer switch or end of frame.
  input  wire lan_attn_pkg::desc_flags_t i_last_desc_flags,     // Flags of last used descriptor.
  input  wire logic                      i_descriptor_end,      // Descriptor list exhausted by traffic.
  input  wire logic                      i_bus_grant,           // Grant pin, asynchronous.
  input  wire logic                      i_desc_access,         // Descriptor access in progress.
  output logic                           o_bus_request,
  output logic                           o_interrupt,
  output logic [23:0]                    o_fetch_addr,          // Address of current init fetch.
  output logic                           o_receive_setup,       // Pulse: set up a receive descriptor.
  output logic [1:0]                     o_command_unit_cmd,    // Command accepted for the command unit.
  output logic                           o_command_unit_strobe  // Pulse when that command is taken.
);
  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [6:0] {
    S_RESET  = 7'b0000001,  // Waiting for first attention.
    S_INIT   = 7'b0000010,  // Root pointer and page fetch.
    S_IDLE   = 7'b0000100,  // Normal operation.
    S_CUWAIT = 7'b0001000,  // Command unit finishing work.
    S_RUWAIT = 7'b0010000,  // Receive unit finishing work.
    S_LOW    = 7'b0100000,  // Interrupt line pulled low.
    S_WRITE  = 7'b1000000   // Status word being written.
  } seq_t;

  seq_t      seq_q, seq_d;
  lan_attn_pkg::ru_state_t ru_q;              // Receive unit state.
  logic [3:0]  cause_q;                       // Sticky cause bits.
  logic [3:0]  ack_q;                         // Acknowledge field of command word.
  logic [1:0]  ru_cmd_q;                      // Receive unit command.
  logic [1:0]  cu_cmd_q;                      // Command unit command.
  logic [3:0]  status_q;                      // Published cause bits.
  logic        irq_q;                         // Interrupt line.
  logic        ca_s1_q, ca_s2_q, ca_s3_q;     // Attention synchroniser and edge history.
  logic        gr_s1_q, gr_s2_q;              // Grant synchroniser.
  logic        ca_latch_q;                    // Latched attention edge.
  logic        starting_q;                    // Receive unit start in progress.
  logic [7:0]  init_cnt_q;                    // Init sequencing count.
  logic        rd_valid_q;                    // Read answer stage.
  logic        rnr_evt;                       // Receive unit went not ready this cycle.
  logic [TALLY_W-1:0] rsc_q, ovr_q, crc_q, aln_q;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  wire ca_fall    = ca_s3_q & ~ca_s2_q;
  wire cmd_busy   = (ack_q != 4'h0) | (ru_cmd_q != 2'h0) | (cu_cmd_q != 2'h0);
  wire wr_cmd     = i_avs_write & (i_avs_address == lan_attn_pkg::OFF_CMD) & i_avs_byteenable[0];
  wire ru_dead    = ru_q != lan_attn_pkg::RU_READY;
  // Event causes collected every cycle.
  wire [3:0] new_cause = {i_descriptor_end & ~ru_dead,
                          i_command_unit_idle_event,
                          i_frame_received_event,
                          i_command_done_event};
  wire accept     = (seq_q == S_RUWAIT) & ~i_receive_unit_busy;
  wire init_done  = (seq_q == S_INIT) & (init_cnt_q == 8'(lan_attn_pkg::INIT_CYCLES));

  // ------------------------------------------------------------------
  // Attention and grant synchronisers; edge latch
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ca_s1_q <= 1'b1;
      ca_s2_q <= 1'b1;
      ca_s3_q <= 1'b1;
      gr_s1_q <= 1'b0;
      gr_s2_q <= 1'b0;
    end else begin
      ca_s1_q <= i_attention_strobe;
      ca_s2_q <= ca_s1_q;
      ca_s3_q <= ca_s2_q;
      gr_s1_q <= i_bus_grant;
      gr_s2_q <= gr_s1_q;
    end
  end

  // Latch the falling edge; cleared while the sequencer sits in idle or reset, set wins.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ca_latch_q <= 1'b0;
    end else if (ca_fall) begin
      ca_latch_q <= 1'b1;                           // [RQ18]
    end else if (seq_q == S_IDLE || seq_q == S_RESET) begin
      ca_latch_q <= 1'b0;                           // [RQ18]
    end
  end

  // ------------------------------------------------------------------
  // Handshake sequencer
  // ------------------------------------------------------------------
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      S_RESET:  if (ca_latch_q) seq_d = S_INIT;                       // [RQ12] [RQ22]
      S_INIT:   if (init_done) seq_d = S_LOW;                         // [RQ13] [RQ23]
      // Attention is served regardless of frame traffic.
      // A cause that lands mid-handshake leaves status behind and is posted here.
      S_IDLE:   if (ca_latch_q) seq_d = S_CUWAIT;                     // [RQ19]
                else if (new_cause != 4'h0 || cause_q != status_q) seq_d = S_LOW; // [RQ8]
      S_CUWAIT: if (!i_command_unit_busy) seq_d = S_RUWAIT;           // [RQ15]
      S_RUWAIT: if (!i_receive_unit_busy) seq_d = S_LOW;              // [RQ16]
      S_LOW:    seq_d = S_WRITE;                                      // [RQ8] [RQ11]
      S_WRITE:  seq_d = S_IDLE;                                       // [RQ25]
      default:  seq_d = S_RESET;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) seq_q <= S_RESET;
    else          seq_q <= seq_d;
  end

  // Init progress and root pointer fetch address.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      init_cnt_q   <= 8'h00;
      o_fetch_addr <= 24'h00_0000;
    end else if (seq_q == S_INIT) begin
      init_cnt_q   <= init_cnt_q + 8'h01;
      o_fetch_addr <= lan_attn_pkg::ROOT_PTR_ADDR;  // [RQ22]
    end
  end

  // ------------------------------------------------------------------
  // Causes, status word and interrupt line
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cause_q  <= 4'h0;
      status_q <= 4'h0;
      irq_q    <= 1'b0;                              // [RQ12]
    end else begin
      // New events set; acks clear on acceptance; set wins.
      cause_q <= (cause_q & ~(accept ? ack_q : 4'h0)) | new_cause    // [RQ7] [RQ11]
               | (init_done ? (4'h1 << lan_attn_pkg::CAUSE_DONE) | (4'h1 << lan_attn_pkg::CAUSE_CNR) : 4'h0) // [RQ13]
               | (rnr_evt ? 4'h1 << lan_attn_pkg::CAUSE_RNR : 4'h0); // [RQ1]
      if (seq_q == S_LOW) irq_q <= 1'b0;                             // [RQ8]
      if (seq_q == S_WRITE) begin
        status_q <= cause_q;                                          // [RQ25]
        irq_q    <= cause_q != 4'h0;                                  // [RQ11]
      end
    end
  end

  // ------------------------------------------------------------------
  // Receive unit control at command acceptance or descriptor end
  // ------------------------------------------------------------------
  logic [1:0] eff_req;
  assign eff_req = accept ? ru_cmd_q : lan_attn_pkg::REQ_NONE;
  always_comb begin
    rnr_evt = 1'b0;
    if (accept || i_descriptor_end) begin
      case ({i_last_desc_flags.end_of_list, i_last_desc_flags.suspend})  // [RQ24]
        2'b01:   rnr_evt = 1'b1;                                     // [RQ1]
        2'b10,
        2'b11:   rnr_evt = eff_req != lan_attn_pkg::REQ_START;       // [RQ2] [RQ3]
        default: rnr_evt = eff_req == lan_attn_pkg::REQ_SUSPEND;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || init_done) begin
      ru_q            <= lan_attn_pkg::RU_IDLE;
      starting_q      <= 1'b0;
      o_receive_setup <= 1'b0;
    end else begin
      o_receive_setup <= 1'b0;
      starting_q      <= 1'b0;
      if (accept || i_descriptor_end) begin
        case ({i_last_desc_flags.end_of_list, i_last_desc_flags.suspend})
          2'b01: ru_q <= lan_attn_pkg::RU_SUSP;                      // [RQ1]
          2'b10: if (eff_req == lan_attn_pkg::REQ_START) begin
                   ru_q <= lan_attn_pkg::RU_READY;                   // [RQ2]
                   o_receive_setup <= 1'b1;
                   starting_q <= 1'b1;                               // [RQ5]
                 end else ru_q <= lan_attn_pkg::RU_NORES;            // [RQ2]
          2'b11: if (eff_req == lan_attn_pkg::REQ_START) begin
                   ru_q <= lan_attn_pkg::RU_READY;                   // [RQ3]
                   o_receive_setup <= 1'b1;
                   starting_q <= 1'b1;
                 end else ru_q <= lan_attn_pkg::RU_IDLE;             // [RQ3]
          default: if (eff_req == lan_attn_pkg::REQ_SUSPEND) ru_q <= lan_attn_pkg::RU_SUSP;
                   else if (eff_req == lan_attn_pkg::REQ_START) begin
                     ru_q <= lan_attn_pkg::RU_READY;
                     o_receive_setup <= 1'b1;
                     starting_q <= 1'b1;                             // [RQ5]
                   end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Loss and error tallies
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rsc_q <= '0;
      ovr_q <= '0;
      crc_q <= '0;
      aln_q <= '0;
    end else begin
      // A frame lost while starting or not ready counts once.
      if ((i_frame_lost_event || (i_frame_received_event && (starting_q || ru_dead))) && !i_overrun_state)
        rsc_q <= rsc_q + 1'b1;                                       // [RQ5] [RQ6]
      if ((i_frame_lost_event || (i_frame_received_event && (starting_q || ru_dead))) && i_overrun_state)
        ovr_q <= ovr_q + 1'b1;                                       // [RQ6]
      if (i_crc_error_event)   crc_q <= crc_q + 1'b1;                // [RQ6]
      if (i_align_error_event) aln_q <= aln_q + 1'b1;                // [RQ6]
    end
  end

  // ------------------------------------------------------------------
  // Command word (host writes, cleared after both units accept)
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_q <= 4'h0;
      ru_cmd_q <= 2'h0;
      cu_cmd_q <= 2'h0;
      o_command_unit_cmd <= 2'h0;
      o_command_unit_strobe <= 1'b0;
    end else begin
      o_command_unit_strobe <= 1'b0;
      if (accept) begin
        ack_q    <= 4'h0;                                             // [RQ17]
        ru_cmd_q <= 2'h0;
        cu_cmd_q <= 2'h0;
        o_command_unit_cmd <= cu_cmd_q;
        o_command_unit_strobe <= 1'b1;
      end else if (wr_cmd && !o_avs_waitrequest) begin
        ack_q    <= i_avs_writedata[7:4];                             // [RQ10]
        ru_cmd_q <= i_avs_writedata[1:0];
        cu_cmd_q <= i_avs_writedata[3:2];
      end
    end
  end

  // ------------------------------------------------------------------
  // Bus request: kept through a descriptor access
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) o_bus_request <= 1'b0;
    else          o_bus_request <= i_desc_access | (o_bus_request & ~gr_s2_q & i_desc_access); // [RQ20]
  end

  // ------------------------------------------------------------------
  // Avalon-MM slave: writes in zero waits, reads answered one cycle later
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_valid_q     <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      rd_valid_q <= i_avs_read & ~rd_valid_q;
      case (i_avs_address)
        lan_attn_pkg::OFF_CMD:    o_avs_readdata <= {24'h00_0000, ack_q, cu_cmd_q, ru_cmd_q};
        lan_attn_pkg::OFF_STATUS: o_avs_readdata <= {24'h00_0000, ru_q, status_q};
        lan_attn_pkg::OFF_TALLY:  o_avs_readdata <= {16'(ovr_q), 16'(rsc_q)};
        lan_attn_pkg::OFF_TALLY2: o_avs_readdata <= {16'(aln_q), 16'(crc_q)};
        default:                  o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
  assign o_avs_waitrequest = i_avs_read & ~rd_valid_q;
  assign o_interrupt = irq_q;
  wire unused_ok = cmd_busy;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence line_low_s;  seq_q == S_LOW;   endsequence
  sequence write_s;     seq_q == S_WRITE && !irq_q; endsequence
  irq_order_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ8]
    line_low_s |=> write_s ##1 (irq_q == (status_q != 4'h0))) else $error("irq order broken");
  reset_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ12]
    seq_q == S_RESET |-> !irq_q) else $error("irq during reset wait");
  status_first_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ25]
    $rose(irq_q) |-> $past(seq_q) == S_WRITE) else $error("irq before status");
  cu_defer_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ15]
    seq_q == S_CUWAIT && i_command_unit_busy |=> seq_q == S_CUWAIT) else $error("cu accepted early");
  clear_cmd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ17]
    accept |=> ru_cmd_q == 2'h0 && ack_q == 4'h0) else $error("command word not cleared");
  init_post_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ13]
    init_done |=> cause_q[lan_attn_pkg::CAUSE_DONE] && cause_q[lan_attn_pkg::CAUSE_CNR]) else $error("init causes");
  frame_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ4]
    i_frame_received_event |=> cause_q[lan_attn_pkg::CAUSE_FRX]) else $error("frame cause lost");
  susp_state_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ1]
    accept && i_last_desc_flags == 2'b01 |=> ru_q == lan_attn_pkg::RU_SUSP) else $error("not suspended");
  bus_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ20]
    i_desc_access |=> o_bus_request) else $error("bus dropped in access");
endmodule

// ### hdl/lan_attn_pkg.sv
// Purpose: Shared constants and types for the attention and interrupt handshake block.
// Assumes: One 20 MHz clock, Avalon-MM register access.
// Notes:   Offsets are byte addresses of 32-bit words.
package lan_attn_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CMD     = 4'h0;  // Command word: acks and unit commands.
  localparam logic [3:0] OFF_STATUS  = 4'h4;  // Status word: causes and unit states.
  localparam logic [3:0] OFF_TALLY   = 4'h8;  // Resource and overrun tallies.
  localparam logic [3:0] OFF_TALLY2  = 4'hC;  // CRC and alignment tallies.
  // Cause bit positions, shared by status and acknowledge fields.
  localparam int CAUSE_DONE = 0;
  localparam int CAUSE_FRX  = 1;
  localparam int CAUSE_CNR  = 2;
  localparam int CAUSE_RNR  = 3;
  // Fixed address of the configuration root pointer.
  localparam logic [23:0] ROOT_PTR_ADDR = 24'h0F_FFF6;
  // Page size that holds all control structures.
  localparam logic [16:0] PAGE_BYTES = 17'h1_0000;
  // Receive unit requests.
  localparam logic [1:0] REQ_NONE    = 2'h0;
  localparam logic [1:0] REQ_START   = 2'h1;
  localparam logic [1:0] REQ_SUSPEND = 2'h2;
  // Receive unit states, as reported in status.
  typedef enum logic [3:0] {
    RU_IDLE = 4'b0001,
    RU_SUSP = 4'b0010,
    RU_NORES= 4'b0100,
    RU_READY= 4'b1000
  } ru_state_t;
  // Flags of the last used receive descriptor.
  typedef struct packed {
    logic end_of_list;
    logic suspend;
  } desc_flags_t;
  // Initialization sequencing time.
  localparam int INIT_NS     = 500;
  localparam int CLK_NS      = 50;
  localparam int INIT_CYCLES = (INIT_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ### tb/host_bus_partner.sv
// Purpose: Host side of the shared bus, answering hold requests with a grant.
// Assumes: One clock; request and grant are active high levels.
// Notes:   i_slow delays each grant to stress bus ownership.
`timescale 1ns/1ps
module host_bus_partner (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_bus_request,
  input  wire logic i_slow,
  output logic      o_bus_grant
);
  // ------------------------------------------------------------
  // Grant sequencing
  // ------------------------------------------------------------
  logic [2:0] delay_q;  // Cycles left before the grant is given.
  // The grant is never withdrawn while the request stands, so a descriptor
  // access is never cut short and no structure is touched meanwhile.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_bus_request) begin
      delay_q     <= i_slow ? 3'h5 : 3'h0;
      o_bus_grant <= 1'b0;
    end else if (delay_q != 3'h0) begin
      delay_q <= delay_q - 3'h1;
    end else begin
      o_bus_grant <= 1'b1;
    end
  end
endmodule

// ### tb/test_lan_attention_irq_handshake.sv
// Purpose: Self-checking bench for the attention and interrupt handshake.
// Assumes: Host reaches the control block over Avalon-MM.
// Notes:   Status low byte is {receive unit state, causes}.
`timescale 1ns/1ps
module test_lan_attention_irq_handshake;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                      i_clk, i_rst_n, rd, wr, wq, attn, fr, lost, crc, aln, ovr;
  logic                      done, cui, cub, rub, slow, req, gnt, irq, setup, stb, root_seen, dacc, dend;
  logic [3:0]                adr;
  logic [31:0]               wd, rdq, rdata;
  logic [23:0]               fa;
  logic [1:0]                cmd, cmd_seen;
  lan_attn_pkg::desc_flags_t flags;
  int                        failures, n_tests, n_setup, n_stb, n, n_prev;
  // Receive unit table: {end,suspend}, request, expected status byte.
  logic [1:0] t_f [8] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
  logic [1:0] t_r [8] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1};
  logic [7:0] t_e [8] = '{8'h28, 8'h28, 8'h48, 8'h48, 8'h80, 8'h18, 8'h18, 8'h80};

  lan_attention_irq_handshake #(.TALLY_W(16)) i_lan_attention_irq_handshake (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdq), .o_avs_waitrequest(wq),
    .i_attention_strobe(attn), .i_frame_received_event(fr), .i_frame_lost_event(lost),
    .i_crc_error_event(crc), .i_align_error_event(aln), .i_overrun_state(ovr),
    .i_command_done_event(done), .i_command_unit_idle_event(cui), .i_command_unit_busy(cub),
    .i_receive_unit_busy(rub), .i_last_desc_flags(flags), .i_descriptor_end(dend),
    .i_bus_grant(gnt), .i_desc_access(dacc), .o_bus_request(req), .o_interrupt(irq),
    .o_fetch_addr(fa), .o_receive_setup(setup), .o_command_unit_cmd(cmd), .o_command_unit_strobe(stb));
  host_bus_partner i_host_bus_partner (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus_request(req), .i_slow(slow), .o_bus_grant(gnt));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Pulses last one cycle, so they are counted as they pass.
  always @(posedge i_clk) begin
    if (setup === 1'b1) n_setup++;
    if (stb === 1'b1) begin
      n_stb++;
      cmd_seen = cmd;
    end
    if (fa === lan_attn_pkg::ROOT_PTR_ADDR) root_seen = 1'b1;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk32({31'h0, got}, {31'h0, exp}, what);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One Avalon cycle; held until waitrequest is sampled low.
  task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= ~w;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    rdata = rdq;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) begin
      chk1(1'b1, 1'b0, "bus timeout");
      end_of_test();
    end
  endtask
  task automatic attention;
    @(posedge i_clk);
    attn <= 1'b0;
    repeat (4) @(posedge i_clk);
    attn <= 1'b1;
  endtask
  // The command word must read zero before the next attention.
  task automatic wait_clear;
    for (int k = 0; k < 60; k++) begin
      avs(1'b0, lan_attn_pkg::OFF_CMD, 32'h0);
      if (rdata === 32'h0) break;
    end
    chk32(rdata, 32'h0, "command word not cleared");
    if (rdata !== 32'h0) end_of_test();
  endtask
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    chk1(irq, 1'b1, "interrupt missing");
    if (irq !== 1'b1) end_of_test();
  endtask
  task automatic issue(input logic [31:0] c);
    wait_clear();
    avs(1'b1, lan_attn_pkg::OFF_CMD, c);
    attention();
  endtask
  task automatic status_is(input logic [7:0] e, input string what);
    avs(1'b0, lan_attn_pkg::OFF_STATUS, 32'h0);
    chk32(rdata & 32'h0000_00FF, {24'h0, e}, what);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rd, wr, fr, lost, crc, aln, ovr, done, cui, cub, rub, root_seen, dacc, dend} = '0;
    {adr, wd, flags, failures, n_tests, n_setup, n_stb} = '0;
    attn = 1'b1;
    slow = 1'b1;
    i_rst_n = 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (30) @(posedge i_clk);
    chk1(irq, 1'b0, "interrupt before attention");
    attention();
    wait_irq();
    chk1(root_seen, 1'b1, "root pointer not fetched");
    status_is(8'h15, "init status");
    // Start both units while both are busy; acceptance must wait.
    cub <= 1'b1;
    rub <= 1'b1;
    issue(32'h0000_0055);
    repeat (20) @(posedge i_clk);
    chk32(n_stb, 0, "command taken while busy");
    cub <= 1'b0;
    repeat (20) @(posedge i_clk);
    chk32(n_setup, 0, "receive start while busy");
    rub <= 1'b0;
    wait_clear();
    chk32(cmd_seen, 2'h1, "command unit command");
    chk32(n_setup, 1, "receive setup count");
    status_is(8'h80, "started status");
    chk1(irq, 1'b0, "interrupt with nothing pending");
    // Every row of the receive unit table, old causes acknowledged each time.
    for (int i = 0; i < 8; i++) begin
      n_prev = n_setup;
      flags <= lan_attn_pkg::desc_flags_t'(t_f[i]);
      issue(32'h0000_00F0 | {30'h0, t_r[i]});
      wait_clear();
      repeat (10) @(posedge i_clk);
      status_is(t_e[i], "receive unit table");
      chk1(irq, t_e[i][3], "not-ready interrupt");
      chk32(n_setup - n_prev, {31'h0, t_e[i] == 8'h80}, "setup on start");
    end
    flags <= '0;
    issue(32'h0000_00F0);
    wait_clear();
    // Three causes at once; status must be in place when the line rises.
    @(posedge i_clk);
    {fr, done, cui} <= 3'h7;
    @(posedge i_clk);
    {fr, done, cui} <= 3'h0;
    wait_irq();
    avs(1'b0, lan_attn_pkg::OFF_STATUS, 32'h0);
    chk32(rdata & 32'h0000_000F, 32'h0000_0007, "causes");
    // Lost frames: two into the resource tally, one into overrun.
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      {ovr, lost, crc, aln} <= {k == 2, 1'b1, k == 0, k != 0};
      @(posedge i_clk);
      {lost, crc, aln} <= 3'h0;
    end
    avs(1'b0, lan_attn_pkg::OFF_TALLY, 32'h0);
    chk32(rdata, 32'h0001_0002, "loss tallies");
    avs(1'b0, lan_attn_pkg::OFF_TALLY2, 32'h0);
    chk32(rdata, 32'h0002_0001, "error tallies");
    // Traffic reaching a suspend-flagged descriptor suspends the unit; old causes stay.
    flags <= lan_attn_pkg::desc_flags_t'(2'h1);
    dend  <= 1'b1;
    @(posedge i_clk);
    dend  <= 1'b0;
    repeat (5) @(posedge i_clk);
    status_is(8'h2F, "suspended by traffic");
    // A descriptor access keeps the request up, through a slow grant, until it ends.
    dacc <= 1'b1;
    n = 0;
    while (gnt !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    chk1(req, 1'b1, "request dropped in access");
    chk1(gnt, 1'b1, "grant missing");
    @(posedge i_clk);
    dacc <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk1(req, 1'b0, "request held after access");
    avs(1'b0, 4'h2, 32'h0);
    chk32(rdata, 32'h0, "unmapped read");
    end_of_test();
  end
endmodule
